//--- logic/cwl_regs.svh
// register selects, field positions and decode constants for cwl_ctrl
`ifndef CWL_REGS_SVH
`define CWL_REGS_SVH
`define CWL_PRIMARY_LOCK      4'h9
`define CWL_PRIMARY_MAINT     4'h7
`define CWL_SEL_LOCK          4'h0
`define CWL_SEL_REGION        4'h1
`define CWL_SEL_PREFETCH      4'hd
`define CWL_OPC_DATA          3'h0
`define CWL_OPC_INSTR         3'h1
`define CWL_OPC_PREFETCH      3'h1
`define CWL_LOCK_RESET        4'h0
`define CWL_LOCK_ONES         12'hfff
`define CWL_LOCK_ZERO_HI      16'h0000
`define CWL_BASE_LSB          12
`define CWL_SIZE_LSB          2
`define CWL_ENABLE_BIT        0
`define CWL_SIZE_ABSENT       4'h0
`define CWL_SIZE_MIN          4'h3
`define CWL_SIZE_MAX          4'hb
`define CWL_SIZE_SHIFT        5'h09
`define CWL_FALLBACK_WAY      2'h3
`endif

//--- logic/cwl_pkg.sv
// shared types for the way lock and local memory region block
package cwl_pkg;
    typedef logic [3:0]  cwl_lock_type;
    typedef logic [19:0] cwl_base_type;
    typedef logic [3:0]  cwl_size_type;
    typedef logic [1:0]  cwl_way_type;
    typedef logic [31:0] cwl_word_type;
endpackage

//--- logic/cwl_ctrl.sv
// way lock and local memory region control registers
//
// Functional notes
// - all way-lock bits clear at reset
// - bit n locks way n from allocation
// - opcode 0 data lock, 1 instruction lock
// - all ways locked sends linefill to way 3
// - instruction prefetch-line op via select 13
// - clearing a lock bit unlocks from the cycle after the write
// - one instruction and one data region
// - base address in bits 31 to 12
// - size field mirrors size pins, not writes
// - size codes 3..11 valid, others none
// - enable bit 0; data enable clears at reset
// - instruction enable follows boot pin at reset
// - disabled region is never accessed
// - instruction memory also serves data accesses
// - fetch in data region goes to main memory
`timescale 1ns/100ps
`include "cwl_regs.svh"
module cwl_ctrl
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         cp_valid,
    input  wire logic         cp_write,
    input  wire logic [3:0]   cp_primary_reg,
    input  wire logic [3:0]   secondary_register_select,
    input  wire logic [2:0]   cp_opcode2,
    input  wire logic [31:0]  cp_wdata,
    output logic              cp_rvalid_reg,
    output logic [31:0]       cp_rdata_reg,
    input  wire logic [3:0]   instr_region_size_pins,
    input  wire logic [3:0]   data_region_size_pins,
    input  wire logic         boot_from_local_mem_pin,
    input  wire logic         d_fill_req,
    input  wire logic [1:0]   d_repl_way,
    output logic              d_fill_valid_reg,
    output logic [1:0]        d_fill_way_reg,
    input  wire logic         i_fill_req,
    input  wire logic [1:0]   i_repl_way,
    output logic              i_fill_valid_reg,
    output logic [1:0]        i_fill_way_reg,
    output logic              prefetch_req_reg,
    output logic [31:0]       prefetch_addr_reg,
    output logic [3:0]        prefetch_lock_reg,
    input  wire logic         fetch_valid,
    input  wire logic [31:0]  fetch_addr,
    input  wire logic         data_valid,
    input  wire logic [31:0]  data_addr,
    output logic              fetch_instr_mem_reg,
    output logic              fetch_main_mem_reg,
    output logic              data_instr_mem_reg,
    output logic              data_data_mem_reg,
    output logic              data_main_mem_reg
);
    cwl_pkg::cwl_lock_type dlock_reg, dlock_next, ilock_reg, ilock_next;
    cwl_pkg::cwl_base_type dbase_reg, dbase_next, ibase_reg, ibase_next;
    logic                  den_reg, den_next, ien_reg, ien_next;
    cwl_pkg::cwl_size_type isz_s1_reg, isz_reg, dsz_s1_reg, dsz_reg;
    logic                  boot_s1_reg, boot_reg;
    logic                  rvalid_next, pf_req_next;
    cwl_pkg::cwl_word_type rdata_next, pf_addr_next;
    cwl_pkg::cwl_lock_type pf_lock_next;
    logic                  dfv_next, ifv_next;
    cwl_pkg::cwl_way_type  dfw_next, ifw_next;
    logic                  fim_next, fmm_next, dim_next, ddm_next, dmm_next;
    logic                  lock_acc, reg_acc, pf_acc, i_hit_f, d_hit_f;
    logic                  i_hit_d, d_hit_d;

    // victim way under a lock mask
    function automatic cwl_pkg::cwl_way_type pick_way(
        input cwl_pkg::cwl_lock_type lock,
        input cwl_pkg::cwl_way_type  prop);
        cwl_pkg::cwl_way_type w;
        w = `CWL_FALLBACK_WAY;
        if (!lock[prop])
        begin
            w = prop;
        end
        else
        begin
            for (int k = 3; k >= 0; k--)
            begin
                if (!lock[k])
                begin
                    w = 2'(k);
                end
            end
        end
        return w;
    endfunction

    // address lies in an enabled, sized region
    function automatic logic region_hit(
        input logic [31:0]           addr,
        input cwl_pkg::cwl_base_type base,
        input cwl_pkg::cwl_size_type size,
        input logic                  en);
        logic [32:0] diff;
        logic [32:0] span;
        diff = {1'b0, addr} - {1'b0, base, 12'h000};
        span = 33'h1 << ({1'b0, size} + `CWL_SIZE_SHIFT);
        return en && size >= `CWL_SIZE_MIN && size <= `CWL_SIZE_MAX
            && !diff[32] && diff < span;
    endfunction

    // size and boot pins cross in through two flops
    always_ff @(posedge clk)
    begin
        isz_s1_reg  <= instr_region_size_pins;
        isz_reg     <= isz_s1_reg;
        dsz_s1_reg  <= data_region_size_pins;
        dsz_reg     <= dsz_s1_reg;
        boot_s1_reg <= boot_from_local_mem_pin;
        boot_reg    <= boot_s1_reg;
    end

    // register transfers, fills and region decode
    always_comb
    begin
        lock_acc = cp_valid && cp_primary_reg == `CWL_PRIMARY_LOCK
            && secondary_register_select == `CWL_SEL_LOCK;
        reg_acc = cp_valid && cp_primary_reg == `CWL_PRIMARY_LOCK
            && secondary_register_select == `CWL_SEL_REGION;
        pf_acc = cp_valid && cp_write
            && cp_primary_reg == `CWL_PRIMARY_MAINT
            && secondary_register_select == `CWL_SEL_PREFETCH
            && cp_opcode2 == `CWL_OPC_PREFETCH;
        dlock_next = dlock_reg;
        ilock_next = ilock_reg;
        dbase_next = dbase_reg;
        ibase_next = ibase_reg;
        den_next = den_reg;
        ien_next = ien_reg;
        if (cp_write && lock_acc && cp_opcode2 == `CWL_OPC_DATA)
        begin
            dlock_next = cp_wdata[3:0];
        end
        if (cp_write && lock_acc && cp_opcode2 == `CWL_OPC_INSTR)
        begin
            ilock_next = cp_wdata[3:0];
        end
        if (cp_write && reg_acc && cp_opcode2 == `CWL_OPC_DATA)
        begin
            dbase_next = cp_wdata[31:`CWL_BASE_LSB];
            den_next = cp_wdata[`CWL_ENABLE_BIT];
        end
        if (cp_write && reg_acc && cp_opcode2 == `CWL_OPC_INSTR)
        begin
            ibase_next = cp_wdata[31:`CWL_BASE_LSB];
            ien_next = cp_wdata[`CWL_ENABLE_BIT];
        end
        if (rst)
        begin
            dlock_next = `CWL_LOCK_RESET;
            ilock_next = `CWL_LOCK_RESET;
            dbase_next = '0;
            ibase_next = '0;
            den_next = 1'b0;
            ien_next = boot_reg;
        end
        rvalid_next = cp_valid && !cp_write && !rst;
        rdata_next = '0;
        if (lock_acc && cp_opcode2 == `CWL_OPC_DATA)
        begin
            rdata_next = {`CWL_LOCK_ZERO_HI, `CWL_LOCK_ONES, dlock_reg};
        end
        else if (lock_acc && cp_opcode2 == `CWL_OPC_INSTR)
        begin
            rdata_next = {`CWL_LOCK_ZERO_HI, `CWL_LOCK_ONES, ilock_reg};
        end
        else if (reg_acc && cp_opcode2 == `CWL_OPC_DATA)
        begin
            rdata_next = {dbase_reg, 6'h00, dsz_reg, 1'b0, den_reg};
        end
        else if (reg_acc && cp_opcode2 == `CWL_OPC_INSTR)
        begin
            rdata_next = {ibase_reg, 6'h00, isz_reg, 1'b0, ien_reg};
        end
        pf_req_next = pf_acc && !rst;
        pf_addr_next = pf_acc ? cp_wdata : prefetch_addr_reg;
        pf_lock_next = pf_acc ? ilock_reg : prefetch_lock_reg;
        dfv_next = d_fill_req && !rst;
        ifv_next = i_fill_req && !rst;
        dfw_next = pick_way(dlock_reg, d_repl_way);
        ifw_next = pick_way(ilock_reg, i_repl_way);
        i_hit_f = region_hit(fetch_addr, ibase_reg, isz_reg, ien_reg);
        d_hit_f = region_hit(fetch_addr, dbase_reg, dsz_reg, den_reg);
        i_hit_d = region_hit(data_addr, ibase_reg, isz_reg, ien_reg);
        d_hit_d = region_hit(data_addr, dbase_reg, dsz_reg, den_reg);
        fim_next = fetch_valid && i_hit_f && !rst;
        fmm_next = fetch_valid && !i_hit_f && !rst;
        ddm_next = data_valid && d_hit_d && !rst;
        dim_next = data_valid && i_hit_d && !d_hit_d && !rst;
        dmm_next = data_valid && !i_hit_d && !d_hit_d && !rst;
        if (d_hit_f)
        begin
            fim_next = 1'b0;
            fmm_next = fetch_valid && !rst;
        end
        if (rst)
        begin
            rdata_next = '0;
            pf_addr_next = '0;
            pf_lock_next = '0;
            dfw_next = '0;
            ifw_next = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        dlock_reg           <= dlock_next;
        ilock_reg           <= ilock_next;
        dbase_reg           <= dbase_next;
        ibase_reg           <= ibase_next;
        den_reg             <= den_next;
        ien_reg             <= ien_next;
        cp_rvalid_reg       <= rvalid_next;
        cp_rdata_reg        <= rdata_next;
        prefetch_req_reg    <= pf_req_next;
        prefetch_addr_reg   <= pf_addr_next;
        prefetch_lock_reg   <= pf_lock_next;
        d_fill_valid_reg    <= dfv_next;
        d_fill_way_reg      <= dfw_next;
        i_fill_valid_reg    <= ifv_next;
        i_fill_way_reg      <= ifw_next;
        fetch_instr_mem_reg <= fim_next;
        fetch_main_mem_reg  <= fmm_next;
        data_instr_mem_reg  <= dim_next;
        data_data_mem_reg   <= ddm_next;
        data_main_mem_reg   <= dmm_next;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_lock_read;
        cp_valid && !cp_write && cp_primary_reg == `CWL_PRIMARY_LOCK
            && secondary_register_select == `CWL_SEL_LOCK;
    endsequence
    sequence s_all_locked_fill;
        d_fill_req && dlock_reg == 4'hf;
    endsequence

    chk_lock_reset_clear: assert property ($fell(rst) |->
        dlock_reg == 4'h0 && ilock_reg == 4'h0)
        else $error("lock bits not clear after reset");
    chk_lock_read_fmt: assert property (s_lock_read |=>
        cp_rvalid_reg && cp_rdata_reg[31:4] == 28'h0000fff)
        else $error("lock read format wrong");
    chk_fallback_way: assert property (s_all_locked_fill |=>
        d_fill_valid_reg && d_fill_way_reg == 2'h3)
        else $error("fully locked fill not in way 3");
    chk_fill_unlocked: assert property (d_fill_req && dlock_reg != 4'hf |=>
        (($past(dlock_reg) >> d_fill_way_reg) & 4'h1) == 4'h0)
        else $error("fill placed in locked way");
    chk_dmem_en_reset: assert property ($fell(rst) |-> !den_reg)
        else $error("data region enabled after reset");
    chk_imem_en_boot: assert property ($fell(rst) |->
        ien_reg == $past(boot_reg))
        else $error("instruction enable not from boot pin");
    chk_size_readback: assert property (cp_valid && !cp_write
        && cp_primary_reg == `CWL_PRIMARY_LOCK
        && secondary_register_select == `CWL_SEL_REGION
        && cp_opcode2 == `CWL_OPC_DATA |=>
        cp_rdata_reg[5:2] == $past(dsz_reg))
        else $error("size field not from pins");
    chk_disabled_no_hit: assert property (!den_reg && !ien_reg |=>
        !data_data_mem_reg && !data_instr_mem_reg
        && !fetch_instr_mem_reg)
        else $error("disabled region accessed");
    chk_fetch_route: assert property (fetch_valid |=>
        fetch_instr_mem_reg != fetch_main_mem_reg)
        else $error("fetch routed wrongly");
    chk_prefetch_pulse: assert property (prefetch_req_reg |->
        prefetch_lock_reg == $past(ilock_reg))
        else $error("prefetch without lock mask");
endmodule

//--- verification/cwl_core_model.sv
// core model issuing coprocessor register transfers
`timescale 1ns/100ps
module cwl_core_model
(
    input  wire logic        clk,
    output logic             cp_valid,
    output logic             cp_write,
    output logic [3:0]       cp_primary_reg,
    output logic [3:0]       secondary_register_select,
    output logic [2:0]       cp_opcode2,
    output logic [31:0]      cp_wdata,
    input  wire logic        cp_rvalid_reg,
    input  wire logic [31:0] cp_rdata_reg
);
    initial
    begin
        cp_valid = 1'b0;
        cp_write = 1'b0;
        cp_primary_reg = 4'h0;
        secondary_register_select = 4'h0;
        cp_opcode2 = 3'h0;
        cp_wdata = 32'h0;
    end
    // one-cycle pulse, answer sampled the cycle after, lines then flipped
    task automatic xfer(input logic wr, input logic [3:0] pri, sel,
        input logic [2:0] opc, input logic [31:0] wd,
        output logic [31:0] rd, output logic rv);
        @(negedge clk);
        cp_valid = 1'b1;
        cp_write = wr;
        cp_primary_reg = pri;
        secondary_register_select = sel;
        cp_opcode2 = opc;
        cp_wdata = wd;
        @(negedge clk);
        rd = cp_rdata_reg;
        rv = cp_rvalid_reg;
        cp_valid = 1'b0;
        cp_write = ~wr;
        cp_primary_reg = ~pri;
        secondary_register_select = ~sel;
        cp_opcode2 = ~opc;
        cp_wdata = ~wd;
    endtask
endmodule

//--- verification/testbench.sv
// self-checking bench for cwl_ctrl
`timescale 1ns/100ps
module testbench;
    typedef struct packed
    {
        logic [3:0] sel; logic [2:0] opc; logic [31:0] wd; logic [31:0] ex;
    } cwl_row_type;
    cwl_row_type rows [5] = '{
        '{4'h0, 3'h0, 32'hffffffff, 32'h0000ffff},
        '{4'h0, 3'h1, 32'hfffffff5, 32'h0000fff5},
        '{4'h1, 3'h0, 32'h10000fff, 32'h1000000d},
        '{4'h1, 3'h1, 32'h20000002, 32'h20000014},
        '{4'h2, 3'h0, 32'hffffffff, 32'h00000000}};
    logic clk, rst, cv, cw, rv, boot, dq, iq, dfv, ifv, pq, fv, dv;
    logic [3:0] cpr, csel, isz, dsz, pl;
    logic [2:0] copc;
    logic [1:0] dp, ip, dw, iw;
    logic [31:0] cwd, crd, rd, pa, fa, da;
    logic [4:0] route;
    int fail_count, total_checks, cycles;
    cwl_core_model core (.clk(clk), .cp_valid(cv), .cp_write(cw),
        .cp_primary_reg(cpr), .secondary_register_select(csel),
        .cp_opcode2(copc), .cp_wdata(cwd), .cp_rvalid_reg(rv),
        .cp_rdata_reg(crd));
    cwl_ctrl dut (.clk(clk), .rst(rst), .cp_valid(cv), .cp_write(cw),
        .cp_primary_reg(cpr), .secondary_register_select(csel),
        .cp_opcode2(copc), .cp_wdata(cwd), .cp_rvalid_reg(rv),
        .cp_rdata_reg(crd), .instr_region_size_pins(isz),
        .data_region_size_pins(dsz), .boot_from_local_mem_pin(boot),
        .d_fill_req(dq), .d_repl_way(dp), .d_fill_valid_reg(dfv),
        .d_fill_way_reg(dw), .i_fill_req(iq), .i_repl_way(ip),
        .i_fill_valid_reg(ifv), .i_fill_way_reg(iw),
        .prefetch_req_reg(pq), .prefetch_addr_reg(pa),
        .prefetch_lock_reg(pl), .fetch_valid(fv), .fetch_addr(fa),
        .data_valid(dv), .data_addr(da), .fetch_instr_mem_reg(route[4]),
        .fetch_main_mem_reg(route[3]), .data_instr_mem_reg(route[2]),
        .data_data_mem_reg(route[1]), .data_main_mem_reg(route[0]));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fail_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] pri, sel, input logic [2:0] opc,
        input logic [31:0] wd);
        logic v;
        core.xfer(1'b1, pri, sel, opc, wd, rd, v);
    endtask
    task automatic rdc(input logic [3:0] sel, input logic [2:0] opc,
        input logic [31:0] ex);
        logic v;
        core.xfer(1'b0, 4'h9, sel, opc, 32'h0, rd, v);
        check({31'h0, v}, 32'h1);
        check(rd, ex);
    endtask
    task automatic fill(input logic [1:0] d, i, de, ie);
        @(negedge clk);
        dq = 1'b1;
        iq = 1'b1;
        dp = d;
        ip = i;
        @(negedge clk);
        check({26'h0, dfv, ifv, dw, iw}, {26'h0, 2'h3, de, ie});
        dq = 1'b0;
        iq = 1'b0;
        dp = ~d;
        ip = ~i;
    endtask
    task automatic acc(input logic [31:0] f, d, input logic [4:0] ex);
        @(negedge clk);
        fv = 1'b1;
        dv = 1'b1;
        fa = f;
        da = d;
        @(negedge clk);
        check({27'h0, route}, {27'h0, ex});
        fv = 1'b0;
        dv = 1'b0;
        fa = ~f;
        da = ~d;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        {rst, dq, iq, fv, dv, dp, ip, fa, da} = '1;
        {isz, dsz, boot} = {4'h5, 4'h3, 1'b1};
        repeat (16) @(negedge clk);
        rst = 1'b0;
        rdc(4'h0, 3'h0, 32'h0000fff0);
        rdc(4'h0, 3'h1, 32'h0000fff0);
        rdc(4'h1, 3'h0, 32'h0000000c);
        rdc(4'h1, 3'h1, 32'h00000015);
        $display("test reset values done");
        foreach (rows[n])
        begin
            wr(4'h9, rows[n].sel, rows[n].opc, rows[n].wd);
            rdc(rows[n].sel, rows[n].opc, rows[n].ex);
        end
        $display("test register rows done");
        fill(2'h1, 2'h0, 2'h3, 2'h1);
        wr(4'h9, 4'h0, 3'h0, 32'h0000000e);
        fill(2'h2, 2'h2, 2'h0, 2'h1);
        wr(4'h9, 4'h0, 3'h0, 32'h00000000);
        fill(2'h2, 2'h3, 2'h2, 2'h3);
        wr(4'h9, 4'h0, 3'h1, 32'hfffffffb);
        wr(4'h7, 4'hd, 3'h1, 32'h20000040);
        check({27'h0, pq, pl}, {27'h0, 1'b1, 4'hb});
        check(pa, 32'h20000040);
        wr(4'h9, 4'h0, 3'h1, 32'h00000007);
        rdc(4'h0, 3'h1, 32'h0000fff7);
        $display("test fills done");
        acc(32'h10000000, 32'h10000ffc, 5'h0a);
        acc(32'h20000000, 32'h10001000, 5'h09);
        wr(4'h9, 4'h1, 3'h1, 32'h20000001);
        acc(32'h20003ffc, 32'h20000000, 5'h14);
        foreach (rows[n])
        begin
            if (n < 2)
            begin
                dsz = n ? 4'hc : 4'h0;
                repeat (3) @(negedge clk);
                rdc(4'h1, 3'h0, 32'h10000001 | {26'h0, dsz, 2'h0});
                acc(32'h20000000, 32'h10000000, 5'h11);
            end
        end
        $display("test routing done");
        {rst, boot} = 2'b10;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        rdc(4'h1, 3'h1, 32'h00000014);
        rdc(4'h0, 3'h1, 32'h0000fff0);
        $display("test second reset done");
        complete_run();
    end
endmodule
